/* File: core/acr_pkg.sv */
package acr_pkg;
	localparam int CMD_W    = 8;
	localparam int REG_W    = 8;
	localparam int WIDE_W   = 24;
	localparam int NARROW_W = 16;
	localparam int ONES_CNT = 32;

	// command byte fields
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_RW_BIT  = 6;
	localparam int CMD_ADDR_HI = 3;

	// target addresses (status answers reads of address zero)
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MODE   = 4'h1;
	localparam logic [3:0] ADDR_CHAN   = 4'h2;
	localparam logic [3:0] ADDR_FILTER = 4'h3;
	localparam logic [3:0] ADDR_DATA   = 4'h4;
	localparam logic [3:0] ADDR_IOCTL  = 4'h7;

	// status bit positions
	localparam int ST_RDY_BIT  = 7;
	localparam int ST_CAL_BIT  = 5;
	localparam int ST_ERR_BIT  = 3;
	localparam int ST_LOCK_BIT = 0;

	// port control bit positions
	localparam int IO_P2DIR_BIT = 5;
	localparam int IO_P1DIR_BIT = 4;
	localparam int IO_P2DAT_BIT = 1;
	localparam int IO_P1DAT_BIT = 0;

	// reset values
	localparam logic [7:0] MODE_RST   = 8'h00;
	localparam logic [7:0] CHAN_RST   = 8'h07;
	localparam logic [7:0] IOCTL_RST  = 8'h00;
	localparam logic [7:0] FILTER_RST = 8'h45;

	typedef enum logic [1:0] {
		ACR_WAIT = 2'b00,
		ACR_WR   = 2'b01,
		ACR_RD   = 2'b10
	} acr_state_t;
endpackage

/* File: core/acr_regbank.sv */
`timescale 1ns/1ps
// serial register bank of the measurement converter
module acr_regbank #(
	parameter int RESULT_W = acr_pkg::WIDE_W
) (
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	input  wire logic                sclk,
	input  wire logic                csN,
	input  wire logic                din,
	output logic                     dout,
	output logic                     doutEn,
	input  wire logic [1:0]          ioIn,
	output logic      [1:0]          ioOut,
	output logic      [1:0]          ioOe,
	input  wire logic                convDone,
	input  wire logic [RESULT_W-1:0] convData,
	input  wire logic                calBusy,
	input  wire logic                errFlag,
	input  wire logic                lockFlag,
	output logic      [7:0]          modeWord,
	output logic      [7:0]          chanRange,
	output logic      [7:0]          filterWord
);
	acr_pkg::acr_state_t stateQ;
	logic [4:0]          bitCntQ;
	logic [3:0]          targetQ;
	logic [7:0]          inShiftQ;
	logic [RESULT_W-1:0] outShiftQ;
	logic                doutQ;
	logic [5:0]          onesCntQ;
	logic                sclkPrevQ;
	logic                rdyQ;
	logic [7:0]          modeQ;
	logic [7:0]          chanQ;
	logic [7:0]          ioctlQ;
	logic [7:0]          filterQ;
	logic [RESULT_W-1:0] dataQ;

	logic                sclkS;
	logic                csS;
	logic                dinS;
	logic [1:0]          ioS;
	logic                sclkRise;
	logic                sclkFall;
	logic [7:0]          shiftByte;
	logic [3:0]          cmdAddr;
	logic                cmdDone;
	logic                cmdValid;
	logic                cmdRead;
	logic [4:0]          lastIdx;
	logic                xferEnd;
	logic                wrDone;
	logic                rdDataDone;
	logic                softRst;
	logic [7:0]          statusVal;
	logic [7:0]          ioctlVal;
	logic [7:0]          reg8Val;
	logic [RESULT_W-1:0] rdValue;

	// pin inputs cross into the core clock
	acr_sync #(
		.W       (5),
		.RST_VAL (5'b00011)
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.asyncIn  ({ioIn, din, csN, sclk}),
		.stable   ({ioS, dinS, csS, sclkS})
	);

	// serial clock edges, only while selected
	assign sclkRise  = sclkS & ~sclkPrevQ & ~csS;
	assign sclkFall  = ~sclkS & sclkPrevQ & ~csS;
	assign shiftByte = {inShiftQ[6:0], dinS};
	assign cmdAddr   = shiftByte[acr_pkg::CMD_ADDR_HI:0];
	assign cmdDone   = (stateQ == acr_pkg::ACR_WAIT) && sclkRise && (bitCntQ == 5'd7);
	assign cmdValid  = cmdDone && !shiftByte[acr_pkg::CMD_WEN_BIT] && !softRst;
	assign cmdRead   = shiftByte[acr_pkg::CMD_RW_BIT];
	// result transfers follow the result width, all other targets take eight bits
	assign lastIdx   = (targetQ == acr_pkg::ADDR_DATA) ? 5'(RESULT_W - 1) : 5'd7;
	assign xferEnd   = (stateQ != acr_pkg::ACR_WAIT) && sclkRise && (bitCntQ == lastIdx);
	assign wrDone    = (stateQ == acr_pkg::ACR_WR) && xferEnd && !softRst;
	assign rdDataDone = (stateQ == acr_pkg::ACR_RD) && xferEnd
		&& (targetQ == acr_pkg::ADDR_DATA);
	assign softRst   = sclkRise && dinS && (onesCntQ == 6'(acr_pkg::ONES_CNT - 1));

	assign statusVal = {rdyQ, 1'b0, calBusy, 1'b0, errFlag, 2'b00, lockFlag};
	// input pins read back their level
	assign ioctlVal  = {ioctlQ[7:2],
		ioctlQ[acr_pkg::IO_P2DIR_BIT] ? ioctlQ[acr_pkg::IO_P2DAT_BIT] : ioS[1],
		ioctlQ[acr_pkg::IO_P1DIR_BIT] ? ioctlQ[acr_pkg::IO_P1DAT_BIT] : ioS[0]};
	assign reg8Val = (cmdAddr == acr_pkg::ADDR_STATUS) ? statusVal :
		(cmdAddr == acr_pkg::ADDR_MODE)   ? modeQ :
		(cmdAddr == acr_pkg::ADDR_CHAN)   ? chanQ :
		(cmdAddr == acr_pkg::ADDR_FILTER) ? filterQ :
		(cmdAddr == acr_pkg::ADDR_IOCTL)  ? ioctlVal : 8'h00;
	assign rdValue = (cmdAddr == acr_pkg::ADDR_DATA) ? dataQ
		: {reg8Val, {(RESULT_W - 8){1'b0}}};

	// pins and control words
	assign dout       = doutQ;
	assign doutEn     = (stateQ == acr_pkg::ACR_RD);
	assign ioOut      = {ioctlQ[acr_pkg::IO_P2DAT_BIT], ioctlQ[acr_pkg::IO_P1DAT_BIT]};
	assign ioOe       = {ioctlQ[acr_pkg::IO_P2DIR_BIT], ioctlQ[acr_pkg::IO_P1DIR_BIT]};
	assign modeWord   = modeQ;
	assign chanRange  = chanQ;
	// one word for both chop settings
	assign filterWord = filterQ;

	// edge history and input shifter
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclkPrevQ <= 1'b1;
			inShiftQ  <= 8'h00;
		end
		else
		begin
			sclkPrevQ <= sclkS;
			if (sclkRise)
				inShiftQ <= shiftByte;
		end
	end

	// consecutive ones counter
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			onesCntQ <= 6'h00;
		else if (softRst || (sclkRise && !dinS))
			onesCntQ <= 6'h00;
		else if (sclkRise)
			onesCntQ <= onesCntQ + 6'h01;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stateQ <= acr_pkg::ACR_WAIT;
		else if (softRst)
			stateQ <= acr_pkg::ACR_WAIT;
		else
		begin
			case (stateQ)
				acr_pkg::ACR_WAIT:
					if (cmdValid)
						stateQ <= cmdRead ? acr_pkg::ACR_RD : acr_pkg::ACR_WR;
				acr_pkg::ACR_WR, acr_pkg::ACR_RD:
					if (xferEnd)
						stateQ <= acr_pkg::ACR_WAIT;
				default:
					stateQ <= acr_pkg::ACR_WAIT;
			endcase
		end
	end

	// bit counter and latched target
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bitCntQ <= 5'h00;
			targetQ <= 4'h0;
		end
		else
		begin
			if (softRst || cmdDone || xferEnd)
				bitCntQ <= 5'h00;
			else if (sclkRise)
				bitCntQ <= bitCntQ + 5'h01;
			if (cmdValid)
				targetQ <= cmdAddr;
		end
	end

	// read shifter, msb first on falling edges
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			outShiftQ <= '0;
			doutQ     <= 1'b0;
		end
		else if (cmdValid && cmdRead)
			outShiftQ <= rdValue;
		else if ((stateQ == acr_pkg::ACR_RD) && sclkFall)
		begin
			doutQ     <= outShiftQ[RESULT_W-1];
			outShiftQ <= {outShiftQ[RESULT_W-2:0], 1'b0};
		end
	end

	// ready flag, a new result wins over the read clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdyQ <= 1'b0;
		else
			rdyQ <= convDone | (rdyQ & ~rdDataDone & ~softRst);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			dataQ <= '0;
		else if (convDone)
			dataQ <= convData;
		else if (softRst)
			dataQ <= '0;
	end

	// writable registers only; status and result ignore writes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			modeQ   <= acr_pkg::MODE_RST;
			chanQ   <= acr_pkg::CHAN_RST;
			ioctlQ  <= acr_pkg::IOCTL_RST;
			filterQ <= acr_pkg::FILTER_RST;
		end
		else if (softRst)
		begin
			modeQ   <= acr_pkg::MODE_RST;
			chanQ   <= acr_pkg::CHAN_RST;
			ioctlQ  <= acr_pkg::IOCTL_RST;
			filterQ <= acr_pkg::FILTER_RST;
		end
		else if (wrDone)
		begin
			if (targetQ == acr_pkg::ADDR_MODE)
				modeQ <= shiftByte;
			if (targetQ == acr_pkg::ADDR_CHAN)
				chanQ <= shiftByte;
			if (targetQ == acr_pkg::ADDR_IOCTL)
				ioctlQ <= shiftByte;
			if (targetQ == acr_pkg::ADDR_FILTER)
				filterQ <= shiftByte;
		end
	end

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence readCmd_s;
		cmdValid && cmdRead;
	endsequence
	sequence writeDone_s(logic [3:0] a);
		wrDone && (targetQ == a) && !convDone;
	endsequence

	cmd_dir_a: assert property (readCmd_s |=> stateQ == acr_pkg::ACR_RD)
		else $error("read command did not start a read");
	cmd_gate_a: assert property ((stateQ == acr_pkg::ACR_WAIT) && !cmdValid
		|=> stateQ == acr_pkg::ACR_WAIT)
		else $error("left command wait without a command");
	target_latch_a: assert property (cmdValid |=> targetQ == $past(cmdAddr))
		else $error("target not latched");
	rdy_clear_a: assert property (rdDataDone && !convDone |=> !rdyQ)
		else $error("ready not cleared by result read");
	mode_write_a: assert property (writeDone_s(acr_pkg::ADDR_MODE)
		|=> modeQ == $past(shiftByte))
		else $error("mode write lost");
	chan_reset_a: assert property (softRst |=> chanQ == 8'h07 ##1 stateQ == acr_pkg::ACR_WAIT)
		else $error("channel byte not reset");
	io_drive_a: assert property (writeDone_s(acr_pkg::ADDR_IOCTL)
		|=> {ioOe, ioOut} == {$past(shiftByte[5:4]), $past(shiftByte[1:0])})
		else $error("port pin drive mismatch");
	filter_reset_a: assert property (softRst |=> filterQ == 8'h45)
		else $error("filter word not reset");
	result_load_a: assert property (convDone |=> dataQ == $past(convData) && rdyQ)
		else $error("result not captured");
	xfer_end_a: assert property (xferEnd |=> stateQ == acr_pkg::ACR_WAIT && bitCntQ == 5'h00)
		else $error("no return to command wait");
	ones_reset_a: assert property (sclkRise && dinS && onesCntQ == 6'd31
		|=> stateQ == acr_pkg::ACR_WAIT && onesCntQ == 6'h00)
		else $error("ones run did not reset");
	data_ro_a: assert property (writeDone_s(acr_pkg::ADDR_DATA) |=> $stable(dataQ))
		else $error("result changed by write");
	msb_out_a: assert property ((stateQ == acr_pkg::ACR_RD) && sclkFall
		|=> doutQ == $past(outShiftQ[RESULT_W-1]))
		else $error("read bit order wrong");
endmodule

/* File: core/acr_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output follows once stages two and three agree
module acr_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] stable
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] stable_q;
	logic [W-1:0] agree;

	// per-bit agreement of the two settled stages
	assign agree  = ~(ff2_q ^ ff3_q);
	assign stable = stable_q;

	// sampling chain
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ff1_q    <= RST_VAL;
			ff2_q    <= RST_VAL;
			ff3_q    <= RST_VAL;
			stable_q <= RST_VAL;
		end
		else
		begin
			ff1_q    <= asyncIn;
			ff2_q    <= ff1_q;
			ff3_q    <= ff2_q;
			stable_q <= (agree & ff3_q) | (~agree & stable_q);
		end
	end
endmodule

/* File: sim/acr_host.sv */
`timescale 1ns/1ps
// host side of the serial link; the link clock idles high between frames
module acr_host (
	output logic      sclk,
	output logic      csN,
	output logic      din,
	input  wire logic dout
);
	// idle: clock high, device deselected
	initial
	begin
		sclk = 1'b1;
		csN  = 1'b1;
		din  = 1'b0;
	end

	// one frame of n bits; data changes on the fall, dout is sampled on the rise
	// msb first both ways
	task automatic xfer(input int n, input logic [31:0] wv, output logic [31:0] rv);
		rv = '0;
		csN = 1'b0;
		#62.5;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk = 1'b0;
			din  = wv[i];
			#62.5;
			sclk = 1'b1;
			rv   = {rv[30:0], dout};
			#62.5;
		end
		// released data line has no pull, so it shows the inverse of its last level
		din = ~din;
		csN = 1'b1;
		#62.5;
	endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
// self-checking bench: register model in integers against the serial bank
module testbench;
	logic        core_clk, rst_n, convDone, calBusy, errFlag, lockFlag;
	logic        sclk, csN, din, dout, doutN, doutEn;
	logic [1:0]  ioIn, ioOut, ioOe;
	logic [23:0] convData;
	logic [15:0] capN;
	logic [7:0]  modeWord, chanRange, filterWord;
	logic [31:0] mdl [8];
	logic [31:0] r, v, res;
	logic        rdy;
	int          seed, errorCnt, cmpCount, cyc;

	acr_regbank #(.RESULT_W(24)) i_acr_regbank (.core_clk(core_clk), .rst_n(rst_n),
		.sclk(sclk), .csN(csN), .din(din), .dout(dout), .doutEn(doutEn), .ioIn(ioIn),
		.ioOut(ioOut), .ioOe(ioOe), .convDone(convDone), .convData(convData),
		.calBusy(calBusy), .errFlag(errFlag), .lockFlag(lockFlag),
		.modeWord(modeWord), .chanRange(chanRange), .filterWord(filterWord));
	acr_host i_acr_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout));

	// narrow variant on the same link, with a data line of its own
	acr_regbank #(.RESULT_W(16)) i_acr_regbank_narrow (.core_clk(core_clk), .rst_n(rst_n),
		.sclk(sclk), .csN(csN), .din(din), .dout(doutN), .doutEn(), .ioIn(ioIn),
		.ioOut(), .ioOe(), .convDone(convDone), .convData(convData[15:0]),
		.calBusy(calBusy), .errFlag(errFlag), .lockFlag(lockFlag),
		.modeWord(), .chanRange(), .filterWord());

	// narrow data line taken at every link clock rise, like the host does
	always @(posedge sclk)
		capN <= {capN[14:0], doutN};

	// clock source
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errorCnt++;
			finalReport();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			errorCnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finalReport();
		if (errorCnt == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input int a, input int n, input logic [31:0] d);
		i_acr_host.xfer(8, 32'(a), r);
		i_acr_host.xfer(n, d, r);
	endtask

	// read through a command byte and compare with the model
	task automatic chkrd(input int a);
		logic [31:0] e;
		e = (a == 1 || a == 2 || a == 3) ? mdl[a] : 32'h0;
		if (a == 0)
			e = {24'h0, rdy, 1'b0, calBusy, 1'b0, errFlag, 2'b00, lockFlag};
		if (a == 4)
			e = res;
		if (a == 7)
			e = {mdl[7][31:2], mdl[7][5] ? mdl[7][1] : ioIn[1], mdl[7][4] ? mdl[7][0] : ioIn[0]};
		i_acr_host.xfer(8, 32'h40 | a, r);
		@(negedge core_clk);
		chk(doutEn, 1'b1);
		i_acr_host.xfer(a == 4 ? 24 : 8, 32'h0, r);
		chk(r, e);
		@(negedge core_clk);
		chk(doutEn, 1'b0);
		if (a == 4)
			rdy = 1'b0;
	endtask

	task automatic mdl_reset();
		mdl = '{32'h0, 32'h0, 32'h07, 32'h45, 32'h0, 32'h0, 32'h0, 32'h0};
		res = 32'h0;
		rdy = 1'b0;
	endtask

	// one-cycle conversion pulse with a fresh random result
	task automatic conv();
		@(posedge core_clk);
		v = $random(seed);
		convData <= v[23:0];
		convDone <= 1'b1;
		@(posedge core_clk);
		convDone <= 1'b0;
		res = {8'h0, v[23:0]};
		rdy = 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	// main sequence
	initial
	begin
		seed = 32'h2a77;
		rst_n = 1'b0;
		convDone = 1'b0;
		convData = 24'h0;
		{calBusy, errFlag, lockFlag} = 3'b000;
		ioIn = 2'b00;
		mdl_reset();
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		v = $random(seed);
		{calBusy, errFlag, lockFlag, ioIn} <= v[4:0];
		repeat (10) @(posedge core_clk);
		foreach (mdl[a])
			chkrd(a);
		for (int a = 0; a < 8; a++)
		begin
			v = $random(seed);
			if (a == 7)
				v = v & 32'h33;
			else
				v = v & 32'hff;
			if ((a > 0 && a < 4) || a == 7)
				mdl[a] = v;
			wr(a, a == 4 ? 24 : 8, v);
		end
		foreach (mdl[a])
			chkrd(a);
		chk({modeWord, chanRange, filterWord}, {8'h0, mdl[1][7:0], mdl[2][7:0], mdl[3][7:0]});
		chk({ioOe, ioOut}, {mdl[7][5:4], mdl[7][1:0]});
		// fresh conversion result, read out msb first and clearing ready
		conv();
		chkrd(0);
		chkrd(4);
		chkrd(0);
		// write-enable bit set: command ignored, next proper command still works
		i_acr_host.xfer(8, 32'h81, r);
		wr(1, 8, 32'h3c);
		mdl[1] = 32'h3c;
		chkrd(1);
		// 32 ones recover the interface and reset the registers
		i_acr_host.xfer(32, 32'hffffffff, r);
		mdl_reset();
		repeat (4) @(posedge core_clk);
		chk({modeWord, chanRange, filterWord}, 32'h000745);
		for (int a = 0; a < 4; a++)
			chkrd(a);
		// narrow variant: 16 result bits, then the last byte of the wide result
		conv();
		i_acr_host.xfer(8, 32'h44, r);
		i_acr_host.xfer(16, 32'h0, r);
		chk(capN, res[15:0]);
		chk(r, res[23:8]);
		i_acr_host.xfer(8, 32'h0, r);
		chk(r, res[7:0]);
		finalReport();
	end
endmodule
